// >>> itc_timer.sv
// Notes on behaviour
// - command bits 7:6 pick counter 0, 1, 2; 11 means read-back command.
// - bits 5:4: 00 latch count, 01 low byte, 10 high byte, 11 low then high.
// - bits 3:1 pick one of six counting modes, X10 and X11 ignore bit 3.
// - bit 0 picks 16-bit binary or four-digit BCD countdown.
// - after programming, a new count may be written any time and applies per mode; here it loads on the next tick in every mode.
// - read-back captures count, mode, output level and null flag of chosen counters.
// - read-back bit 5 low latches count; high leaves count alone.
// - read-back bit 4 low latches status; high leaves status alone.
// - read-back bits 3, 2, 1 select counters 2, 1, 0; unselected stay unlatched.
// - with count and status both latched, successive reads return both.
// - latch command snapshots the count at receipt; counting goes on.
// - latch commands to a counter already holding an unread latch are ignored.
// - two-byte latched reads keep their order across accesses to other counters.
// - after a latch command, reads return the latched count, not the live one.
// - counters 0, 1, 2 sit at consecutive ports for count and status access.
// - latched status is returned on the next read, before any latched count.
// - status: bit 7 output level, bit 6 null flag, bits 5:0 echo programming.
`timescale 1ns/1ps
`default_nettype none
`include "itc_params.svh"

module itc_timer #(
	parameter int TICK_DIV = `ITC_TICK_DIV
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire itc_pkg::itc_io_req_t io_req_in,
	output logic [7:0] io_rdata_out,
	output logic io_rvalid_out,
	output logic [2:0] timer_out_out
);

	localparam int NCNT = 3;

	itc_pkg::itc_chan_t chan_q [NCNT];
	itc_pkg::itc_chan_t next_chan [NCNT];
	logic [15:0] div_q;
	logic [15:0] next_div;
	logic tick;
	logic [7:0] rdata_q;
	logic [7:0] next_rdata;
	logic rvalid_q;
	logic next_rvalid;

	// one borrow-chain step; bcd wraps each digit 0 -> 9
	function automatic logic [15:0] dec_count(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		logic borrow;
		logic [3:0] nib;
		r = v;
		borrow = 1'b1;
		if (!bcd) begin
			r = v - 16'h0001;
		end else begin
			for (int k = 0; k < 4; k++) begin
				nib = v[4*k +: 4];
				if (borrow) begin
					if (nib == 4'h0) begin
						nib = `ITC_BCD_TOP_DIGIT;
					end else begin
						nib = nib - 4'h1;
						borrow = 1'b0;
					end
				end
				r[4*k +: 4] = nib;
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] status_of(input itc_pkg::itc_chan_t c);
		return {c.out_lvl, c.null_cnt, c.cfg};
	endfunction

	always_comb begin
		logic [15:0] nxt;
		logic [15:0] val;
		logic last;
		logic [7:0] d;
		nxt = 16'h0000;
		val = 16'h0000;
		last = 1'b0;
		d = io_req_in.wdata;
		tick = (div_q == 16'(TICK_DIV - 1));
		next_div = tick ? 16'h0000 : div_q + 16'h0001;
		next_rdata = rdata_q;
		next_rvalid = 1'b0;
		for (int i = 0; i < NCNT; i++) begin
			next_chan[i] = chan_q[i];
			// counting element; a pending count is moved in on the next tick
			if (tick) begin
				if (chan_q[i].load_pend) begin
					next_chan[i].ce = chan_q[i].count_holding_register;
					next_chan[i].load_pend = 1'b0;
					next_chan[i].null_cnt = 1'b0;
					next_chan[i].armed = 1'b1;
				end else if (chan_q[i].armed) begin
					nxt = dec_count(chan_q[i].ce, chan_q[i].cfg.bcd);
					if (chan_q[i].cfg.mode[1:0] == `ITC_MODE_LOW_RATE) begin
						if (chan_q[i].ce == `ITC_CE_ONE) begin
							next_chan[i].ce = chan_q[i].count_holding_register;
							next_chan[i].out_lvl = 1'b1;
						end else begin
							next_chan[i].ce = nxt;
							next_chan[i].out_lvl = (chan_q[i].ce != `ITC_CE_TWO);
						end
					end else if (chan_q[i].cfg.mode[1:0] == `ITC_MODE_LOW_SQUARE) begin
						// half period per reload gives a full period of twice the count
						if (chan_q[i].ce == `ITC_CE_ONE) begin
							next_chan[i].ce = chan_q[i].count_holding_register;
							next_chan[i].out_lvl = ~chan_q[i].out_lvl;
						end else begin
							next_chan[i].ce = nxt;
						end
					end else begin
						next_chan[i].ce = nxt;
						if (chan_q[i].cfg.mode == `ITC_MODE_STROBE_SW ||
								chan_q[i].cfg.mode == `ITC_MODE_STROBE_HW) begin
							next_chan[i].out_lvl = (nxt != 16'h0000);
						end else if (nxt == 16'h0000) begin
							next_chan[i].out_lvl = 1'b1;
						end
					end
				end
			end
		end
		// command port
		if (io_req_in.wr && io_req_in.addr == `ITC_PORT_CMD) begin
			if (d[`ITC_SEL_HI:`ITC_SEL_LO] == `ITC_SEL_READBACK) begin
				for (int i = 0; i < NCNT; i++) begin
					if (d[`ITC_RB_SEL_BASE + i]) begin
						if (!d[`ITC_RB_NO_COUNT] && !chan_q[i].cnt_held) begin
							next_chan[i].cnt_held = 1'b1;
							next_chan[i].cnt_latch = chan_q[i].ce;
						end
						if (!d[`ITC_RB_NO_STATUS] && !chan_q[i].sts_held) begin
							next_chan[i].sts_held = 1'b1;
							next_chan[i].sts_latch = status_of(chan_q[i]);
						end
					end
				end
			end else begin
				for (int i = 0; i < NCNT; i++) begin
					if (d[`ITC_SEL_HI:`ITC_SEL_LO] == 2'(i)) begin
						if (d[`ITC_RW_HI:`ITC_RW_LO] == `ITC_RW_LATCH) begin
							// a second latch before the read keeps the first snapshot
							if (!chan_q[i].cnt_held) begin
								next_chan[i].cnt_held = 1'b1;
								next_chan[i].cnt_latch = chan_q[i].ce;
							end
						end else begin
							next_chan[i].cfg = d[`ITC_CFG_HI:`ITC_CFG_LO];
							next_chan[i].null_cnt = 1'b1;
							next_chan[i].load_pend = 1'b0;
							next_chan[i].armed = 1'b0;
							next_chan[i].cnt_held = 1'b0;
							next_chan[i].sts_held = 1'b0;
							next_chan[i].wr_ph = itc_pkg::ITC_PH_LOW;
							next_chan[i].rd_ph = itc_pkg::ITC_PH_LOW;
							next_chan[i].out_lvl = (d[`ITC_MODE_HI:`ITC_MODE_LO] != `ITC_MODE_TERMINAL);
						end
					end
				end
			end
		end
		// counter ports
		for (int i = 0; i < NCNT; i++) begin
			if (io_req_in.addr == `ITC_PORT_CNT0 + 8'(i)) begin
				if (io_req_in.wr) begin
					last = 1'b0;
					case (chan_q[i].cfg.rw)
						`ITC_RW_LOW: begin
							next_chan[i].count_holding_register = {8'h00, d};
							last = 1'b1;
						end
						`ITC_RW_HIGH: begin
							next_chan[i].count_holding_register = {d, 8'h00};
							last = 1'b1;
						end
						`ITC_RW_BOTH: begin
							if (chan_q[i].wr_ph == itc_pkg::ITC_PH_LOW) begin
								next_chan[i].count_holding_register[7:0] = d;
								next_chan[i].wr_ph = itc_pkg::ITC_PH_HIGH;
							end else begin
								next_chan[i].count_holding_register[15:8] = d;
								next_chan[i].wr_ph = itc_pkg::ITC_PH_LOW;
								last = 1'b1;
							end
						end
						default: begin
							last = 1'b0;
						end
					endcase
					if (last) begin
						next_chan[i].load_pend = 1'b1;
						next_chan[i].null_cnt = 1'b1;
						if (chan_q[i].cfg.mode == `ITC_MODE_TERMINAL) begin
							next_chan[i].out_lvl = 1'b0;
						end
					end
				end else if (io_req_in.rd) begin
					next_rvalid = 1'b1;
					last = 1'b0;
					val = chan_q[i].cnt_held ? chan_q[i].cnt_latch : chan_q[i].ce;
					if (chan_q[i].sts_held) begin
						next_rdata = chan_q[i].sts_latch;
						next_chan[i].sts_held = 1'b0;
					end else begin
						case (chan_q[i].cfg.rw)
							`ITC_RW_HIGH: begin
								next_rdata = val[15:8];
								last = 1'b1;
							end
							`ITC_RW_BOTH: begin
								// per-counter byte pointer, untouched by other counters
								if (chan_q[i].rd_ph == itc_pkg::ITC_PH_LOW) begin
									next_rdata = val[7:0];
									next_chan[i].rd_ph = itc_pkg::ITC_PH_HIGH;
								end else begin
									next_rdata = val[15:8];
									next_chan[i].rd_ph = itc_pkg::ITC_PH_LOW;
									last = 1'b1;
								end
							end
							default: begin
								next_rdata = val[7:0];
								last = 1'b1;
							end
						endcase
						if (last) begin
							next_chan[i].cnt_held = 1'b0;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < NCNT; i++) begin
				chan_q[i] <= '0;
			end
			div_q <= 16'h0000;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			for (int i = 0; i < NCNT; i++) begin
				chan_q[i] <= next_chan[i];
			end
			div_q <= next_div;
			rdata_q <= next_rdata;
			rvalid_q <= next_rvalid;
		end
	end

	assign io_rdata_out = rdata_q;
	assign io_rvalid_out = rvalid_q;

	for (genvar g = 0; g < NCNT; g++) begin : g_out
		assign timer_out_out[g] = chan_q[g].out_lvl;
	end

endmodule

`default_nettype wire

// >>> itc_params.svh
`ifndef ITC_PARAMS_SVH
`define ITC_PARAMS_SVH

// i/o ports of the three counters and the command port
`define ITC_PORT_CNT0 8'h40
`define ITC_PORT_CMD 8'h43

// command word fields
`define ITC_SEL_HI 7
`define ITC_SEL_LO 6
`define ITC_RW_HI 5
`define ITC_RW_LO 4
`define ITC_RB_NO_COUNT 5
`define ITC_RB_NO_STATUS 4
`define ITC_RB_SEL_BASE 1
`define ITC_CFG_HI 5
`define ITC_CFG_LO 0
`define ITC_MODE_HI 3
`define ITC_MODE_LO 1
`define ITC_SEL_READBACK 2'h3
`define ITC_RW_LATCH 2'h0
`define ITC_RW_LOW 2'h1
`define ITC_RW_HIGH 2'h2
`define ITC_RW_BOTH 2'h3

// counting modes
`define ITC_MODE_TERMINAL 3'h0
`define ITC_MODE_ONESHOT 3'h1
`define ITC_MODE_STROBE_SW 3'h4
`define ITC_MODE_STROBE_HW 3'h5
`define ITC_MODE_LOW_RATE 2'h2
`define ITC_MODE_LOW_SQUARE 2'h3

// counting-element constants
`define ITC_BCD_TOP_DIGIT 4'h9
`define ITC_CE_ONE 16'h0001
`define ITC_CE_TWO 16'h0002

// timing: counting tick period and system clock period, in ns
`define ITC_TICK_NS 838
`define ITC_CLK_NS 25
`define ITC_TICK_DIV (`ITC_TICK_NS / `ITC_CLK_NS)

`endif

// >>> itc_pkg.sv
package itc_pkg;

	typedef enum logic {
		ITC_PH_LOW = 1'b0,
		ITC_PH_HIGH = 1'b1
	} itc_phase_t;

	// same bit layout as command word bits 5:0 and status bits 5:0
	typedef struct packed {
		logic [1:0] rw;
		logic [2:0] mode;
		logic bcd;
	} itc_cfg_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} itc_io_req_t;

	typedef struct packed {
		itc_cfg_t cfg;
		logic [15:0] count_holding_register;
		logic [15:0] ce;
		logic load_pend;
		logic armed;
		logic null_cnt;
		logic out_lvl;
		logic cnt_held;
		logic [15:0] cnt_latch;
		logic sts_held;
		logic [7:0] sts_latch;
		itc_phase_t wr_ph;
		itc_phase_t rd_ph;
	} itc_chan_t;

endpackage

// >>> itc_host.sv
`timescale 1ns/1ps
`default_nettype none
module itc_host (
	input wire logic clk_in,
	input wire logic [7:0] io_rdata_in,
	input wire logic io_rvalid_in,
	output var itc_pkg::itc_io_req_t io_req_out
);
	initial io_req_out = '0;
	// released address and data lines show the inverse of their last value, never a stale copy; rd and wr go low
	task automatic put(input logic r, w, input logic [7:0] a, d);
		@(posedge clk_in);
		io_req_out <= '{rd: r, wr: w, addr: a, wdata: d};
		@(posedge clk_in);
		io_req_out <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic wr(input logic [7:0] a, d);
		put(1'b0, 1'b1, a, d);
	endtask
	// one byte per call, so callers can split the two count bytes across reads of other counters
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		put(1'b1, 1'b0, a, 8'h00);
		#1;
		d = io_rdata_in;
		v = io_rvalid_in;
	endtask
endmodule
`default_nettype wire

// >>> itc_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module itc_timer_chk #(
	parameter int TICK_DIV = 33
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire itc_pkg::itc_io_req_t io_req_in,
	input wire logic [7:0] io_rdata_out,
	input wire logic io_rvalid_out,
	input wire logic [2:0] timer_out_out
);
	logic [7:0] a, d;
	logic [5:0] cfg0, next_cfg0;
	logic rdc, prog0, rb0;
	assign a = io_req_in.addr;
	assign d = io_req_in.wdata;
	assign rdc = io_req_in.rd && a >= 8'h40 && a <= 8'h42;
	assign prog0 = io_req_in.wr && a == 8'h43 && d[7:6] == 2'h0 && d[5:4] != 2'h0;
	assign rb0 = io_req_in.wr && a == 8'h43 && d[7:6] == 2'h3 && !d[4] && d[1];
	// counter 0 programming, so its status echo can be predicted
	always_comb next_cfg0 = prog0 ? d[5:0] : cfg0;
	always_ff @(posedge clk_in) cfg0 <= resetn_in ? next_cfg0 : 6'h00;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	a_read_answered: assert property (rdc |=> io_rvalid_out)
		else $error("read not answered");
	a_no_stray_valid: assert property (io_rvalid_out |-> $past(rdc))
		else $error("stray read valid");
	a_cmd_read_silent: assert property (
		io_req_in.rd && a == 8'h43 |=> !io_rvalid_out) else $error("command port answered");
	a_write_silent: assert property (io_req_in.wr |=> !io_rvalid_out)
		else $error("write answered");
	a_rdata_held: assert property (!io_rvalid_out |-> $stable(io_rdata_out))
		else $error("read data moved");
	a_mode0_low: assert property (
		prog0 && d[3:1] == 3'h0 |-> ##[1:2] !timer_out_out[0]) else $error("mode 0 not low");
	a_status_echo: assert property (
		rb0 ##2 (rdc && a == 8'h40) |=> io_rdata_out[5:0] == cfg0
		&& io_rdata_out[7] == $past(timer_out_out[0], 3)) else $error("status mismatch");
	a_null_after_prog: assert property (
		prog0 ##2 rb0 ##2 (rdc && a == 8'h40) |=> io_rdata_out[6])
		else $error("null flag clear");
endmodule
bind itc_timer itc_timer_chk #(.TICK_DIV(TICK_DIV)) itc_timer_chk_i (.clk_in(clk_in),
	.resetn_in(resetn_in), .io_req_in(io_req_in), .io_rdata_out(io_rdata_out),
	.io_rvalid_out(io_rvalid_out), .timer_out_out(timer_out_out));
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int TD = 4;
	logic clk_in, resetn_in, io_rvalid_out;
	logic [7:0] io_rdata_out;
	logic [2:0] timer_out_out;
	itc_pkg::itc_io_req_t io_req_in;
	int miscompares, n_compared;
	itc_timer #(.TICK_DIV(TD)) itc_timer_i (.clk_in(clk_in), .resetn_in(resetn_in),
		.io_req_in(io_req_in), .io_rdata_out(io_rdata_out),
		.io_rvalid_out(io_rvalid_out), .timer_out_out(timer_out_out));
	itc_host itc_host_i (.clk_in(clk_in), .io_rdata_in(io_rdata_out),
		.io_rvalid_in(io_rvalid_out), .io_req_out(io_req_in));
	task automatic check(input logic ok, input string what);
		n_compared++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask
	task automatic get(input int c, output logic [7:0] d);
		logic v;
		itc_host_i.rd(8'h40 + 8'(c), d, v);
		check(v === 1'b1 && ^d !== 1'bx, "no read answer");
	endtask
	// count as an integer; a bad decimal digit pushes it far out of any range
	function automatic int val(input logic [15:0] v, input logic b);
		val = b ? 0 : int'(v);
		if (b)
			for (int i = 3; i >= 0; i--)
				val = val * 10 + (v[4*i+:4] > 4'h9 ? 99999 : int'(v[4*i+:4]));
	endfunction
	task automatic t_status;
		logic [7:0] s, cw;
		for (int i = 0; i < 8; i++) begin
			cw = {2'(i % 3), 2'(i % 3 + 1), 3'(i), 1'($urandom)};
			itc_host_i.wr(8'h43, cw);
			itc_host_i.wr(8'h43, 8'he0 | 8'(2 << (i % 3)));
			get(i % 3, s);
			check(s === {1'(i != 0), 1'b1, cw[5:0]}, "status byte");
		end
		$display("status test done");
	endtask
	task automatic t_latch(input logic b);
		logic [7:0] lo, hi, s;
		logic [15:0] n;
		logic vv;
		int v, w, u;
		n = b ? 16'h5080 : {8'($urandom_range(255, 16)), 8'h80};
		itc_host_i.wr(8'h43, {2'h0, 5'h1a, b});
		itc_host_i.wr(8'h40, n[7:0]);
		itc_host_i.wr(8'h40, n[15:8]);
		repeat (3 * TD) @(posedge clk_in);
		itc_host_i.wr(8'h43, 8'h00);
		repeat (4 * TD) @(posedge clk_in);
		itc_host_i.wr(8'h43, 8'h00);
		get(0, lo);
		itc_host_i.wr(8'h43, 8'h74);
		get(1, s);
		get(0, hi);
		v = val({hi, lo}, b);
		check(v <= val(n, b) && v + 5 >= val(n, b), "latched count");
		itc_host_i.wr(8'h43, 8'hc2);
		get(0, s);
		check(s === {2'h2, 2'h3, 3'h2, b}, "status after latch");
		get(0, lo);
		get(0, hi);
		w = val({hi, lo}, b);
		check(w + 4 <= v && w + 10 >= v, "read-back count");
		repeat (2 * TD) @(posedge clk_in);
		get(0, lo);
		get(0, hi);
		u = val({hi, lo}, b);
		check(u + 2 <= w && u + 7 >= w, "live count after release");
		itc_host_i.rd(8'h43, s, vv);
		check(vv === 1'b0, "command port answered");
		itc_host_i.wr(8'h43, 8'hd2);
		get(0, lo);
		get(0, hi);
		w = val({hi, lo}, b);
		check(w < u && w + 3 >= u, "count-only read-back");
		$display("latch test done, bcd %0d", b);
	endtask
	task automatic conclude;
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	initial begin
		#500000;
		miscompares++;
		conclude;
	end
	initial begin
		resetn_in = 1'b0;
		void'($urandom(34));
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		t_status;
		t_latch(1'b0);
		t_latch(1'b1);
		conclude;
	end
endmodule
`default_nettype wire
